//--- core/sfpr_params.svh
// constants for the flash power, reset and rescue sequencer
// assumes a 250 MHz system clock; included by the core and the bench
// Summary of operation
// - below supply threshold: held reset, command frames ignored; the rescue sequence and control-register writes still act
// - power-up phase accepts only the two status reads
// - power-up done: standby, latches clear, locks zero
// - after both parts: extended single-line, no execute-in-place
// - light activity: ready within 40 ns of reset release
// - array operation interrupted: recover within 30 us
// - status or config write: recovery takes full write time
// - program/subsector suspend 7/15 us; then reads only
// - sector suspend 15 us; blocks erase and nonvolatile writes
`ifndef SFPR_PARAMS_SVH
`define SFPR_PARAMS_SVH
`define SFPR_CLK_NS 4
`define SFPR_RST_PULSE_NS 50
`define SFPR_RST_PULSE_CYC ((`SFPR_RST_PULSE_NS + `SFPR_CLK_NS - 1) / `SFPR_CLK_NS)
`define SFPR_RECOV_FAST_NS 40
`define SFPR_RECOV_FAST_CYC (`SFPR_RECOV_FAST_NS / `SFPR_CLK_NS)
`define SFPR_RECOV_ARRAY_US 30
`define SFPR_SUPPLY_FULL_US 150
`define SFPR_STATUS_WRITE_US 1000
`define SFPR_NVCR_WRITE_US 1000
`define SFPR_PROG_SUSP_US 7
`define SFPR_ERASE_SUSP_US 15
`define SFPR_US_CYC(us) (((us) * 1000) / `SFPR_CLK_NS)
`define SFPR_BURST_A 6'h07
`define SFPR_BURST_B 6'h0D
`define SFPR_BURST_C 6'h19
`define SFPR_BURST_BYTE 6'h08
`define SFPR_OP_RD_STATUS 8'h01
`define SFPR_OP_RD_FLAG 8'h02
`define SFPR_OP_READ 8'h03
`define SFPR_OP_WR_ENABLE 8'h04
`define SFPR_OP_ER_SUB 8'h10
`define SFPR_OP_ER_SECT 8'h11
`define SFPR_OP_ER_BULK 8'h12
`define SFPR_OP_WR_STATUS 8'h20
`define SFPR_OP_WR_NVCFG 8'h21
`define SFPR_OP_WR_OTP 8'h22
`define SFPR_REG_CTRL 8'h00
`define SFPR_REG_STAT 8'h04
`define SFPR_REG_LAST 8'h08
`define SFPR_REG_LOCK 8'h0C
`define SFPR_RESP_OKAY 2'h0
`define SFPR_RESP_DECERR 2'h3
`endif

//--- core/sfpr_pkg.sv
// types shared by the sequencer core and its bench
// assumes sfpr_params.svh sits in the include path
`default_nettype none
package sfpr_pkg;
  typedef enum logic [2:0] {ST_OFF = 3'b000, ST_POWERUP = 3'b001, ST_STANDBY = 3'b010,
    ST_RESET = 3'b011, ST_RECOVER = 3'b100} sfpr_state_e;
  typedef enum logic [1:0] {PR_EXT = 2'b00, PR_DUAL = 2'b01, PR_QUAD = 2'b10} sfpr_proto_e;
  typedef enum logic [1:0] {SU_NONE = 2'b00, SU_PROG = 2'b01, SU_SUBSEC = 2'b10,
    SU_SECTOR = 2'b11} sfpr_susp_e;
  typedef enum logic [2:0] {ACT_IDLE = 3'b000, ACT_READ = 3'b001, ACT_ARRAY = 3'b010,
    ACT_WRSR = 3'b011, ACT_NVCR = 3'b100} sfpr_act_e;
endpackage
`default_nettype wire

//--- core/sfpr_core.sv
// power-up filter, rescue detector, reset recovery and suspend gate of a serial flash
// assumes an AXI4-Lite master on clock; sclk stands still while select_n is high
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sfpr_params.svh"
module sfpr_core #(
  parameter int NUM_LOCK = 8,
  parameter int SUPPLY_CYC = `SFPR_US_CYC(`SFPR_SUPPLY_FULL_US),
  parameter int ARRAY_CYC = `SFPR_US_CYC(`SFPR_RECOV_ARRAY_US),
  parameter int WRSR_CYC = `SFPR_US_CYC(`SFPR_STATUS_WRITE_US),
  parameter int NVCR_CYC = `SFPR_US_CYC(`SFPR_NVCR_WRITE_US)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic serial_io_line_zero,
  input wire logic serial_io_line_three,
  input wire logic reset_n,
  input wire logic power_good,
  input wire sfpr_pkg::sfpr_act_e op_kind,
  input wire logic suspend_req,
  input wire sfpr_pkg::sfpr_susp_e suspend_kind,
  input wire logic resume_req,
  output sfpr_pkg::sfpr_state_e state,
  output logic device_ready,
  output sfpr_pkg::sfpr_proto_e protocol,
  output logic execute_in_place,
  output logic wel,
  output logic wip,
  output logic [NUM_LOCK-1:0] lock_wl,
  output logic [NUM_LOCK-1:0] lock_ld,
  output sfpr_pkg::sfpr_susp_e suspended,
  output logic cmd_accept,
  output logic cmd_reject,
  output logic [7:0] cmd_opcode,
  output logic rescue_done
);
  import sfpr_pkg::*;

  localparam int PULSE_CYC = `SFPR_RST_PULSE_CYC;
  localparam int FAST_CYC = `SFPR_RECOV_FAST_CYC;

  // ****************************************
  // link side, on the host's clock
  // ****************************************
  logic lk_run;
  logic [5:0] lk_cnt;
  logic lk_ones;
  logic [7:0] lk_op;

  // select high clears the frame marker; counters hold for the system side
  always_ff @(posedge sclk or posedge rst or posedge select_n)
  begin
    if (rst || select_n)
      lk_run <= 1'b0;
    else
      lk_run <= 1'b1;
  end

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      lk_cnt <= 6'h00;
      lk_ones <= 1'b0;
      lk_op <= 8'h00;
    end
    else
    begin
      lk_cnt <= !lk_run ? 6'h01 : (lk_cnt == 6'h3F ? lk_cnt : lk_cnt + 6'h01);
      lk_ones <= (lk_run ? lk_ones : 1'b1) & serial_io_line_zero & serial_io_line_three;
      lk_op <= {(lk_run ? lk_op[6:0] : 7'h00), serial_io_line_zero};
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sel_sync;
  logic [2:0] rst_sync;
  logic [2:0] pwr_sync;
  logic sel_q;
  logic rstn_q;
  logic pwr_q;

  // a level changes only once the second and third stages agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sel_sync <= 3'h7;
      rst_sync <= 3'h7;
      pwr_sync <= 3'h0;
      sel_q <= 1'b1;
      rstn_q <= 1'b1;
      pwr_q <= 1'b0;
    end
    else
    begin
      sel_sync <= {sel_sync[1:0], select_n};
      rst_sync <= {rst_sync[1:0], reset_n};
      pwr_sync <= {pwr_sync[1:0], power_good};
      if (sel_sync[2] == sel_sync[1])
        sel_q <= sel_sync[2];
      if (rst_sync[2] == rst_sync[1])
        rstn_q <= rst_sync[2];
      if (pwr_sync[2] == pwr_sync[1])
        pwr_q <= pwr_sync[2];
    end
  end

  // link counters are static here: sclk has stopped and the gap outlasts the sync delay
  wire sel_rise = sel_sync[2] & sel_sync[1] & ~sel_q;

  // ****************************************
  // frame judgement and command filter
  // ****************************************
  logic [1:0] resc_step;
  wire ones_frame = sel_rise && lk_ones;
  wire resc_final = ones_frame && resc_step == 2'h3 && lk_cnt == `SFPR_BURST_BYTE;
  wire is_stat = lk_op == `SFPR_OP_RD_STATUS || lk_op == `SFPR_OP_RD_FLAG;
  wire is_read = is_stat || lk_op == `SFPR_OP_READ;
  wire is_erase = lk_op == `SFPR_OP_ER_SUB || lk_op == `SFPR_OP_ER_SECT || lk_op == `SFPR_OP_ER_BULK;
  wire is_heavy = is_erase || lk_op == `SFPR_OP_WR_STATUS || lk_op == `SFPR_OP_WR_NVCFG
    || lk_op == `SFPR_OP_WR_OTP;
  // only extended single-line opcodes are decoded; other modes carry no opcode here
  wire frame_cmd = sel_rise && lk_cnt == `SFPR_BURST_BYTE && protocol == PR_EXT && !execute_in_place
    && !resc_final && state != ST_OFF;
  wire susp_reads = suspended == SU_PROG || suspended == SU_SUBSEC;
  wire cmd_ok = state == ST_POWERUP ? is_stat :
    state != ST_STANDBY ? 1'b0 :
    susp_reads ? is_read :
    suspended == SU_SECTOR ? !is_heavy : 1'b1;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_opcode <= 8'h00;
      resc_step <= 2'h0;
      rescue_done <= 1'b0;
    end
    else
    begin
      cmd_accept <= frame_cmd && cmd_ok;
      cmd_reject <= frame_cmd && !cmd_ok;
      if (frame_cmd)
        cmd_opcode <= lk_op;
      rescue_done <= resc_final;
      // part one in order, then the all-ones byte; anything else starts over
      if (sel_rise)
      begin
        if (ones_frame && lk_cnt == `SFPR_BURST_A)
          resc_step <= 2'h1;
        else if (ones_frame && resc_step == 2'h1 && lk_cnt == `SFPR_BURST_B)
          resc_step <= 2'h2;
        else if (ones_frame && resc_step == 2'h2 && lk_cnt == `SFPR_BURST_C)
          resc_step <= 2'h3;
        else
          resc_step <= 2'h0;
      end
    end
  end

  // ****************************************
  // power, reset and recovery sequence
  // ****************************************
  logic [31:0] tmr;
  logic [7:0] rlow_cnt;
  sfpr_act_e rec_act;
  wire rst_long = !rstn_q && rlow_cnt >= 8'(PULSE_CYC - 1);
  // heavier work left behind stretches the wait
  wire [31:0] next_rec = rec_act == ACT_WRSR ? 32'(WRSR_CYC - 1) :
    rec_act == ACT_NVCR ? 32'(NVCR_CYC - 1) :
    rec_act == ACT_ARRAY ? 32'(ARRAY_CYC - 1) : 32'(FAST_CYC - 1);
  logic [7:0] s_axi_awaddr_q;
  logic [3:0] wr_strb_q;
  wire wr_fire;
  wire [31:0] wr_data;
  wire ctrl_wr = wr_fire && s_axi_awaddr_q == `SFPR_REG_CTRL && wr_strb_q[0];
  wire lock_wr = wr_fire && s_axi_awaddr_q == `SFPR_REG_LOCK && wr_strb_q[0];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_OFF;
      tmr <= 32'h0;
      rlow_cnt <= 8'h00;
      rec_act <= ACT_IDLE;
      device_ready <= 1'b0;
    end
    else
    begin
      device_ready <= state == ST_STANDBY;
      rlow_cnt <= rstn_q ? 8'h00 : (rst_long ? rlow_cnt : rlow_cnt + 8'h01);
      if (!pwr_q)
        state <= ST_OFF;
      else
        case (state)
          ST_OFF:
          begin
            state <= ST_POWERUP;
            tmr <= 32'(SUPPLY_CYC - 1);
          end
          ST_POWERUP:
          begin
            if (tmr == 32'h0)
              state <= ST_STANDBY;
            else
              tmr <= tmr - 32'h1;
          end
          ST_RESET:
          begin
            if (rstn_q)
            begin
              state <= ST_RECOVER;
              tmr <= next_rec;
            end
          end
          ST_STANDBY, ST_RECOVER:
          begin
            // shorter reset pulses are ignored
            if (rst_long)
            begin
              state <= ST_RESET;
              rec_act <= suspended != SU_NONE ? ACT_ARRAY : op_kind;
            end
            else if (state == ST_RECOVER && tmr == 32'h0)
              state <= ST_STANDBY;
            else if (state == ST_RECOVER)
              tmr <= tmr - 32'h1;
          end
          default:
            state <= ST_OFF;
        endcase
    end
  end

  // ****************************************
  // latches, protocol and suspend
  // ****************************************
  sfpr_susp_e sus_pend;
  logic [11:0] sus_cnt;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      protocol <= PR_EXT;
      execute_in_place <= 1'b0;
      wel <= 1'b0;
      wip <= 1'b0;
      lock_wl <= '0;
      lock_ld <= '0;
      suspended <= SU_NONE;
      sus_pend <= SU_NONE;
      sus_cnt <= 12'h000;
    end
    else
    begin
      if (state == ST_POWERUP || state == ST_OFF || state == ST_RESET)
      begin
        wel <= 1'b0;
        wip <= 1'b0;
        suspended <= SU_NONE;
        sus_pend <= SU_NONE;
        if (state != ST_RESET)
        begin
          lock_wl <= '0;
          lock_ld <= '0;
        end
      end
      else
      begin
        wip <= op_kind == ACT_ARRAY || op_kind == ACT_WRSR || op_kind == ACT_NVCR;
        if (cmd_accept && cmd_opcode == `SFPR_OP_WR_ENABLE)
          wel <= 1'b1;
        // latency modelled as a fixed wait before the suspend state shows
        if (suspend_req && sus_pend == SU_NONE && suspended == SU_NONE)
        begin
          sus_pend <= suspend_kind;
          sus_cnt <= suspend_kind == SU_PROG ? 12'(`SFPR_US_CYC(`SFPR_PROG_SUSP_US) - 1) :
            12'(`SFPR_US_CYC(`SFPR_ERASE_SUSP_US) - 1);
        end
        else if (sus_pend != SU_NONE && sus_cnt == 12'h000)
        begin
          suspended <= sus_pend;
          sus_pend <= SU_NONE;
        end
        else if (sus_pend != SU_NONE)
          sus_cnt <= sus_cnt - 12'h001;
        else if (resume_req)
          suspended <= SU_NONE;
        // lock-down freezes the write-lock bit until the next power-up
        if (lock_wr)
        begin
          lock_wl <= (lock_wl & lock_ld) | (wr_data[NUM_LOCK-1:0] & ~lock_ld);
          lock_ld <= lock_ld | wr_data[2*NUM_LOCK-1:NUM_LOCK];
        end
      end
      if (resc_final)
      begin
        protocol <= PR_EXT;
        execute_in_place <= 1'b0;
      end
      else if (ctrl_wr)
      begin
        protocol <= sfpr_proto_e'(wr_data[1:0] == 2'h3 ? 2'h0 : wr_data[1:0]);
        execute_in_place <= wr_data[2];
      end
    end
  end

  // ****************************************
  // register bus slave
  // ****************************************
  logic [31:0] w_data;
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_data = w_data;
  wire wr_hit = s_axi_awaddr_q == `SFPR_REG_CTRL || s_axi_awaddr_q == `SFPR_REG_STAT
    || s_axi_awaddr_q == `SFPR_REG_LAST || s_axi_awaddr_q == `SFPR_REG_LOCK;
  wire rd_hit = s_axi_araddr == `SFPR_REG_CTRL || s_axi_araddr == `SFPR_REG_STAT
    || s_axi_araddr == `SFPR_REG_LAST || s_axi_araddr == `SFPR_REG_LOCK;
  wire [31:0] rd_mux = s_axi_araddr == `SFPR_REG_CTRL ? {29'h0, execute_in_place, protocol} :
    s_axi_araddr == `SFPR_REG_STAT ? {16'h0, 6'h00, resc_step, suspended, device_ready, wip, wel,
      state} :
    s_axi_araddr == `SFPR_REG_LAST ? {16'h0, cmd_reject, cmd_accept, 6'h0, cmd_opcode} :
    s_axi_araddr == `SFPR_REG_LOCK ? 32'({lock_ld, lock_wl}) : 32'h0;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SFPR_RESP_OKAY;
      s_axi_awaddr_q <= 8'h00;
      wr_strb_q <= 4'h0;
      w_data <= 32'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SFPR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        s_axi_awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SFPR_RESP_OKAY : `SFPR_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `SFPR_RESP_OKAY : `SFPR_RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_off_silent;
    @(posedge clock) disable iff (rst) (state == ST_OFF) |=> !cmd_accept && !cmd_reject;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("command answered while off");

  property p_powerup_status;
    @(posedge clock) disable iff (rst) ($past(state) == ST_POWERUP && cmd_accept)
      |-> (cmd_opcode == `SFPR_OP_RD_STATUS || cmd_opcode == `SFPR_OP_RD_FLAG);
  endproperty
  a_powerup_status: assert property (p_powerup_status) else $error("non-status accepted at power-up");

  property p_powerup_clear;
    @(posedge clock) disable iff (rst) (state == ST_STANDBY && $past(state) == ST_POWERUP)
      |-> !wel && !wip && lock_wl == '0 && lock_ld == '0;
  endproperty
  a_powerup_clear: assert property (p_powerup_clear) else $error("latches not clear after power-up");

  property p_rescue_ext;
    @(posedge clock) disable iff (rst) rescue_done |-> protocol == PR_EXT && !execute_in_place;
  endproperty
  a_rescue_ext: assert property (p_rescue_ext) else $error("rescue left wrong protocol");

  property p_fast_recover;
    @(posedge clock) disable iff (rst) ($rose(state == ST_RECOVER) && rec_act == ACT_IDLE && pwr_q)
      |-> ##[1:FAST_CYC] (state == ST_STANDBY || !pwr_q || rst_long);
  endproperty
  a_fast_recover: assert property (p_fast_recover) else $error("idle recovery too slow");

  property p_array_recover;
    @(posedge clock) disable iff (rst) ($rose(state == ST_RECOVER) && rec_act == ACT_ARRAY)
      |-> tmr == 32'(ARRAY_CYC - 1);
  endproperty
  a_array_recover: assert property (p_array_recover) else $error("array recovery time wrong");

  property p_susp_reads;
    @(posedge clock) disable iff (rst) (cmd_accept && ($past(suspended) == SU_PROG
      || $past(suspended) == SU_SUBSEC)) |-> (cmd_opcode == `SFPR_OP_RD_STATUS
      || cmd_opcode == `SFPR_OP_RD_FLAG || cmd_opcode == `SFPR_OP_READ);
  endproperty
  a_susp_reads: assert property (p_susp_reads) else $error("non-read accepted while suspended");

  property p_sector_block;
    @(posedge clock) disable iff (rst) (cmd_accept && $past(suspended) == SU_SECTOR)
      |-> !(cmd_opcode == `SFPR_OP_ER_SECT || cmd_opcode == `SFPR_OP_WR_NVCFG
      || cmd_opcode == `SFPR_OP_ER_SUB || cmd_opcode == `SFPR_OP_ER_BULK
      || cmd_opcode == `SFPR_OP_WR_OTP || cmd_opcode == `SFPR_OP_WR_STATUS);
  endproperty
  a_sector_block: assert property (p_sector_block) else $error("blocked command during sector suspend");
endmodule
`default_nettype wire

//--- testbench/sfpr_host_model.sv
// host side of the serial link: frames of link clocks under select
// assumes the bench calls frame() from its own sequence; link clock idles low
`timescale 1ns/100ps
`default_nettype none
module sfpr_host_model (
  output logic sclk,
  output logic select_n,
  output logic serial_io_line_zero,
  output logic serial_io_line_three
);
  initial
  begin
    sclk = 1'b0;
    select_n = 1'b1;
    serial_io_line_zero = 1'b0;
    serial_io_line_three = 1'b0;
  end
  // ************************************************************
  // one frame: byte frames carry op msb first, bursts are all ones
  // ************************************************************
  task automatic frame(input int n, input logic [7:0] op);
    #3;
    select_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      serial_io_line_zero = (n == 8) ? op[7 - i] : 1'b1;
      serial_io_line_three = 1'b1;
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 select_n = 1'b1;
    // released lines must not keep looking valid
    serial_io_line_zero = ~serial_io_line_zero;
    serial_io_line_three = ~serial_io_line_three;
    #64;
  endtask
endmodule
`default_nettype wire

//--- testbench/serial_flash_power_reset_recovery_tb_top.sv
// self-checking bench for the flash power, reset and rescue sequencer
// assumes sfpr_params.svh in the include path and the host model beside it
`timescale 1ns/100ps
`default_nettype none
`include "sfpr_params.svh"
module serial_flash_power_reset_recovery_tb_top;
  import sfpr_pkg::*;
  // shortened counts keep the run small
  // power-up must outlast the three status-phase command frames
  localparam int SUP_N = 400, ARR_N = 30, WRSR_N = 50, NVCR_N = 60;
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready, reset_n, power_good, suspend_req, resume_req;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  sfpr_act_e op_kind;
  sfpr_susp_e suspend_kind;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic sclk, select_n, line0, line3;
  sfpr_state_e state;
  sfpr_proto_e protocol;
  sfpr_susp_e suspended;
  logic device_ready, execute_in_place, wel, wip, cmd_accept, cmd_reject, rescue_done;
  logic [7:0] lock_wl, lock_ld, cmd_opcode;
  int fails = 0, total_checks = 0, n_acc = 0, n_rej = 0, n_resc = 0, cyc = 0;
  sfpr_core #(.SUPPLY_CYC(SUP_N), .ARRAY_CYC(ARR_N), .WRSR_CYC(WRSR_N), .NVCR_CYC(NVCR_N)) DUT (
    .clock, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready, .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rready), .sclk, .select_n, .serial_io_line_zero(line0),
    .serial_io_line_three(line3), .reset_n, .power_good, .op_kind, .suspend_req, .suspend_kind, .resume_req,
    .state, .device_ready, .protocol, .execute_in_place, .wel, .wip, .lock_wl, .lock_ld, .suspended,
    .cmd_accept, .cmd_reject, .cmd_opcode, .rescue_done);
  sfpr_host_model u_host (.sclk, .select_n, .serial_io_line_zero(line0), .serial_io_line_three(line3));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    n_acc += (cmd_accept === 1'b1);
    n_rej += (cmd_reject === 1'b1);
    n_resc += (rescue_done === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  // ************************************************************
  // compare, report and bus tasks
  // ************************************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid && s_axi_awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && s_axi_wready === 1'b1)
        wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", `SFPR_RESP_OKAY, 32'(s_axi_bresp));
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && s_axi_arready === 1'b1)
        arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rready <= 1'b0;
    check("rdata", d, s_axi_rdata);
    check("rresp", 32'(r), 32'(s_axi_rresp));
  endtask
  // ************************************************************
  // link frames and device activity
  // ************************************************************
  task automatic cmd(input logic [7:0] op, input logic acc, input logic rej);
    int a0;
    int r0;
    a0 = n_acc;
    r0 = n_rej;
    u_host.frame(8, op);
    repeat (4) @(posedge clock);
    check("accept", 32'(acc), 32'(n_acc - a0));
    check("reject", 32'(rej), 32'(n_rej - r0));
    if (acc || rej)
      check("opcode", 32'(op), 32'(cmd_opcode));
  endtask
  task automatic dev_reset(input sfpr_act_e k, input int lo);
    int n;
    op_kind <= k;
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (24) @(posedge clock);
    check("held", ST_RESET, 32'(state));
    reset_n <= 1'b1;
    n = 0;
    while (device_ready !== 1'b1 && n < lo + 30)
    begin
      @(posedge clock);
      n++;
    end
    check("recovery", 1, 32'(n >= lo && n <= lo + 10));
    op_kind <= ACT_IDLE;
  endtask
  task automatic suspend(input sfpr_susp_e k, input int lat);
    @(posedge clock);
    op_kind <= ACT_ARRAY;
    suspend_kind <= k;
    suspend_req <= 1'b1;
    @(posedge clock);
    suspend_req <= 1'b0;
    repeat (lat - 20) @(posedge clock);
    check("early", SU_NONE, 32'(suspended));
    repeat (40) @(posedge clock);
    check("suspended", k, 32'(suspended));
  endtask
  task automatic resume();
    @(posedge clock);
    resume_req <= 1'b1;
    @(posedge clock);
    resume_req <= 1'b0;
    op_kind <= ACT_IDLE;
    repeat (8) @(posedge clock);
    check("resumed", SU_NONE, 32'(suspended));
  endtask
  task automatic rescue(input int a, input int b, input int c, input int d);
    u_host.frame(a, 8'hFF);
    u_host.frame(b, 8'hFF);
    u_host.frame(c, 8'hFF);
    u_host.frame(d, 8'hFF);
    repeat (4) @(posedge clock);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    static logic [7:0] blocked [6] = '{`SFPR_OP_ER_SUB, `SFPR_OP_ER_SECT, `SFPR_OP_ER_BULK, `SFPR_OP_WR_STATUS,
      `SFPR_OP_WR_NVCFG, `SFPR_OP_WR_OTP};
    int n;
    {rst, awvalid, wvalid, bready, arvalid, rready, power_good, suspend_req, resume_req} = 9'h100;
    {awaddr, araddr, wdata, wstrb} = '0;
    reset_n = 1'b1;
    op_kind = ACT_IDLE;
    suspend_kind = SU_NONE;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("off", ST_OFF, 32'(state));
    cmd(`SFPR_OP_RD_STATUS, 1'b0, 1'b0);
    power_good <= 1'b1;
    n = 0;
    while (state !== ST_POWERUP && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    cmd(`SFPR_OP_READ, 1'b0, 1'b1);
    cmd(`SFPR_OP_RD_STATUS, 1'b1, 1'b0);
    cmd(`SFPR_OP_RD_FLAG, 1'b1, 1'b0);
    while (device_ready !== 1'b1 && n < SUP_N + 60)
    begin
      @(posedge clock);
      n++;
    end
    check("flags", 32'h0, {wel, wip, lock_wl, lock_ld});
    axi_read(`SFPR_REG_STAT, 32'h22, `SFPR_RESP_OKAY);
    axi_read(`SFPR_REG_LOCK, 32'h0, `SFPR_RESP_OKAY);
    axi_read(8'h10, 32'h0, `SFPR_RESP_DECERR);
    axi_write(`SFPR_REG_CTRL, 32'h6);
    axi_read(`SFPR_REG_CTRL, 32'h6, `SFPR_RESP_OKAY);
    // lock-down bit set first freezes its write-lock bit
    axi_write(`SFPR_REG_LOCK, 32'h0103);
    axi_write(`SFPR_REG_LOCK, 32'h0000);
    axi_read(`SFPR_REG_LOCK, 32'h0101, `SFPR_RESP_OKAY);
    rescue(7, 13, 8, 25);
    check("no_rescue", 0, n_resc);
    check("still_quad", PR_QUAD, 32'(protocol));
    rescue(7, 13, 25, 8);
    check("rescued", 1, n_resc);
    check("mode", {PR_EXT, 1'b0}, 32'({protocol, execute_in_place}));
    axi_read(`SFPR_REG_CTRL, 32'h0, `SFPR_RESP_OKAY);
    cmd(`SFPR_OP_WR_NVCFG, 1'b1, 1'b0);
    cmd(`SFPR_OP_WR_ENABLE, 1'b1, 1'b0);
    check("wel", 1, 32'(wel));
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (10) @(posedge clock);
    check("short_pulse", ST_STANDBY, 32'(state));
    dev_reset(ACT_IDLE, 10);
    dev_reset(ACT_READ, 10);
    dev_reset(ACT_ARRAY, ARR_N);
    dev_reset(ACT_WRSR, WRSR_N);
    dev_reset(ACT_NVCR, NVCR_N);
    suspend(SU_PROG, 1750);
    cmd(`SFPR_OP_READ, 1'b1, 1'b0);
    cmd(`SFPR_OP_WR_ENABLE, 1'b0, 1'b1);
    resume();
    suspend(SU_SUBSEC, 3750);
    cmd(`SFPR_OP_RD_FLAG, 1'b1, 1'b0);
    cmd(`SFPR_OP_ER_SECT, 1'b0, 1'b1);
    resume();
    suspend(SU_SECTOR, 3750);
    foreach (blocked[i])
      cmd(blocked[i], 1'b0, 1'b1);
    cmd(`SFPR_OP_READ, 1'b1, 1'b0);
    cmd(`SFPR_OP_WR_ENABLE, 1'b1, 1'b0);
    resume();
    results();
  end
endmodule
`default_nettype wire
